//--- common/gcn_pkg.sv
// package: constants, state types and register map of the gpio port block
package gcn_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PORT_W  = 16;
  localparam int CN_W    = 21;
  localparam int CN_LO_W = 16;
  localparam int CN_HI_W = 5;
  localparam int ADDR_W  = 8;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_PIN_DIRECTION  = 8'h00;
  localparam logic [7:0] OFF_OUTPUT_LATCH   = 8'h04;
  localparam logic [7:0] OFF_PIN_LEVEL      = 8'h08;
  localparam logic [7:0] OFF_OPEN_DRAIN     = 8'h0C;
  localparam logic [7:0] OFF_ANALOG_CFG     = 8'h10;
  localparam logic [7:0] OFF_CHG_EN_LO      = 8'h14;
  localparam logic [7:0] OFF_CHG_EN_HI      = 8'h18;
  localparam logic [7:0] OFF_PULLUP_LO      = 8'h1C;
  localparam logic [7:0] OFF_PULLUP_HI      = 8'h20;
  localparam logic [7:0] OFF_CHG_STATUS     = 8'h24;

  // ****************************************************************
  // reset values and implemented bits
  // ****************************************************************
  // which port bits exist on this build; arbitrary example value
  localparam logic [15:0] IMPL_MASK     = 16'h9FFF;
  localparam logic [15:0] DIR_RST       = 16'hFFFF;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [20:0] ZERO21        = 21'h000000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0]
  {
    GCN_WR_IDLE = 2'h1,
    GCN_WR_RESP = 2'h2
  } gcn_wr_state_t;

  typedef struct packed
  {
    logic [15:0]   dir;
    logic [15:0]   latch;
    logic [15:0]   odc;
    logic [15:0]   analog;
    logic [20:0]   cn_en;
    logic [20:0]   pu;
    logic [20:0]   cn_prev;
    logic [20:0]   cn_chg;
    logic          armed;
    logic [15:0]   pin_smp;
    logic [15:0]   pin_o;
    logic [15:0]   pin_oe_n;
    logic [15:0]   periph_in;
    logic          irq;
    logic          wake;
    gcn_wr_state_t wst;
    logic          aw_got;
    logic [7:0]    aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } gcn_state_t;

  localparam gcn_state_t STATE_RST = '{
    dir:       DIR_RST & IMPL_MASK,
    latch:     ZERO16,
    odc:       ZERO16,
    analog:    ZERO16,
    cn_en:     ZERO21,
    pu:        ZERO21,
    cn_prev:   ZERO21,
    cn_chg:    ZERO21,
    armed:     1'b0,
    pin_smp:   ZERO16,
    pin_o:     ZERO16,
    pin_oe_n:  16'hFFFF,
    periph_in: ZERO16,
    irq:       1'b0,
    wake:      1'b0,
    wst:       GCN_WR_IDLE,
    aw_got:    1'b0,
    aw_addr:   8'h00,
    w_got:     1'b0,
    w_data:    32'h00000000,
    w_strb:    4'h0,
    awready:   1'b1,
    wready:    1'b1,
    bvalid:    1'b0,
    bresp:     RESP_OKAY,
    arready:   1'b1,
    rvalid:    1'b0,
    rresp:     RESP_OKAY,
    rdata:     32'h00000000
  };

endpackage

//--- core/gcn_gpio_port.sv
// gpio port with peripheral sharing, open drain and change notification
`timescale 1ns/10ps

module gcn_gpio_port
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [15:0] PIN_I,
  output logic [15:0]      PIN_O,
  output logic [15:0]      PIN_OE_N,
  input  wire logic [15:0] PERIPH_EN,
  input  wire logic [15:0] PERIPH_DRIVE,
  input  wire logic [15:0] PERIPH_OUT,
  output logic [15:0]      PERIPH_IN,
  input  wire logic [20:0] CN_IN,
  output logic [20:0]      PULLUP_EN,
  input  wire logic        SLEEP,
  output logic             CN_IRQ,
  output logic             WAKE_REQ
);

  gcn_pkg::gcn_state_t s_reg;
  gcn_pkg::gcn_state_t s_next;

  // byte-lane merge of a write into a 32 bit image
  function automatic logic [31:0] merge32
  (
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [15:0] own;
  logic [15:0] data_src;
  logic [15:0] drv;
  logic [20:0] detect;
  logic [20:0] clr;
  logic [31:0] m;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_next = s_reg;
    clr    = gcn_pkg::ZERO21;
    m      = 32'h00000000;

    // pin ownership and driver
    own      = PERIPH_EN & PERIPH_DRIVE;
    data_src = (own & PERIPH_OUT) | (~own & s_reg.latch);
    drv      = (own | ~s_reg.dir) & gcn_pkg::IMPL_MASK;
    s_next.pin_o    = data_src & ~s_reg.odc & gcn_pkg::IMPL_MASK;
    s_next.pin_oe_n = ~(drv & ~(s_reg.odc & data_src));
    // peripheral input blocked while port drives the pin
    s_next.periph_in = PIN_I & ~(~own & ~s_reg.dir)
                       & gcn_pkg::IMPL_MASK;
    s_next.pin_smp   = PIN_I & gcn_pkg::IMPL_MASK;

    // change detection, runs every edge including sleep
    detect = (CN_IN ^ s_reg.cn_prev) & s_reg.cn_en
             & {21{s_reg.armed}};
    s_next.cn_prev = CN_IN;
    s_next.armed   = 1'b1;

    // write channel
    if (s_reg.awready && AWVALID)
    begin
      s_next.aw_addr = AWADDR;
      s_next.aw_got  = 1'b1;
    end
    if (s_reg.wready && WVALID)
    begin
      s_next.w_data = WDATA;
      s_next.w_strb = WSTRB;
      s_next.w_got  = 1'b1;
    end
    case (s_reg.wst)
      gcn_pkg::GCN_WR_IDLE:
      begin
        if (s_reg.aw_got && s_reg.w_got)
        begin
          s_next.aw_got = 1'b0;
          s_next.w_got  = 1'b0;
          s_next.bvalid = 1'b1;
          s_next.bresp  = gcn_pkg::RESP_OKAY;
          s_next.wst    = gcn_pkg::GCN_WR_RESP;
          case (s_reg.aw_addr)
            gcn_pkg::OFF_PIN_DIRECTION:
            begin
              m = merge32({16'h0000, s_reg.dir}, s_reg.w_data, s_reg.w_strb);
              s_next.dir = m[15:0] & gcn_pkg::IMPL_MASK;
            end
            gcn_pkg::OFF_OUTPUT_LATCH, gcn_pkg::OFF_PIN_LEVEL:
            begin
              m = merge32({16'h0000, s_reg.latch}, s_reg.w_data,
                          s_reg.w_strb);
              s_next.latch = m[15:0] & gcn_pkg::IMPL_MASK;
            end
            gcn_pkg::OFF_OPEN_DRAIN:
            begin
              m = merge32({16'h0000, s_reg.odc}, s_reg.w_data, s_reg.w_strb);
              s_next.odc = m[15:0] & gcn_pkg::IMPL_MASK;
            end
            gcn_pkg::OFF_ANALOG_CFG:
            begin
              m = merge32({16'h0000, s_reg.analog}, s_reg.w_data,
                          s_reg.w_strb);
              s_next.analog = m[15:0] & gcn_pkg::IMPL_MASK;
            end
            gcn_pkg::OFF_CHG_EN_LO:
            begin
              m = merge32({16'h0000, s_reg.cn_en[15:0]}, s_reg.w_data,
                          s_reg.w_strb);
              s_next.cn_en[15:0] = m[15:0];
            end
            gcn_pkg::OFF_CHG_EN_HI:
            begin
              m = merge32({27'h0000000, s_reg.cn_en[20:16]}, s_reg.w_data,
                          s_reg.w_strb);
              s_next.cn_en[20:16] = m[4:0];
            end
            gcn_pkg::OFF_PULLUP_LO:
            begin
              m = merge32({16'h0000, s_reg.pu[15:0]}, s_reg.w_data,
                          s_reg.w_strb);
              s_next.pu[15:0] = m[15:0];
            end
            gcn_pkg::OFF_PULLUP_HI:
            begin
              m = merge32({27'h0000000, s_reg.pu[20:16]}, s_reg.w_data,
                          s_reg.w_strb);
              s_next.pu[20:16] = m[4:0];
            end
            gcn_pkg::OFF_CHG_STATUS:
            begin
              m   = merge32(32'h00000000, s_reg.w_data, s_reg.w_strb);
              clr = m[20:0];
            end
            default:
            begin
              s_next.bresp = gcn_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      gcn_pkg::GCN_WR_RESP:
      begin
        if (BREADY)
        begin
          s_next.bvalid = 1'b0;
          s_next.wst    = gcn_pkg::GCN_WR_IDLE;
        end
      end
      default:
      begin
        s_next.wst = gcn_pkg::GCN_WR_IDLE;
      end
    endcase
    s_next.awready = (s_next.wst == gcn_pkg::GCN_WR_IDLE) && !s_next.aw_got;
    s_next.wready  = (s_next.wst == gcn_pkg::GCN_WR_IDLE) && !s_next.w_got;

    // sticky flags, a new change beats a clear
    s_next.cn_chg = (s_reg.cn_chg & ~clr) | detect;
    s_next.irq    = |s_next.cn_chg;
    s_next.wake   = s_next.irq && SLEEP;

    // read channel
    if (s_reg.arready && ARVALID)
    begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = gcn_pkg::RESP_OKAY;
      s_next.rdata   = 32'h00000000;
      case (ARADDR)
        gcn_pkg::OFF_PIN_DIRECTION: s_next.rdata[15:0] = s_reg.dir;
        gcn_pkg::OFF_OUTPUT_LATCH:  s_next.rdata[15:0] = s_reg.latch;
        // analog pins read low whatever their direction
        gcn_pkg::OFF_PIN_LEVEL:
          s_next.rdata[15:0] = s_reg.pin_smp
                               & ~s_reg.analog;
        gcn_pkg::OFF_OPEN_DRAIN:    s_next.rdata[15:0] = s_reg.odc;
        gcn_pkg::OFF_ANALOG_CFG:    s_next.rdata[15:0] = s_reg.analog;
        gcn_pkg::OFF_CHG_EN_LO:     s_next.rdata[15:0] = s_reg.cn_en[15:0];
        gcn_pkg::OFF_CHG_EN_HI:     s_next.rdata[4:0]  = s_reg.cn_en[20:16];
        gcn_pkg::OFF_PULLUP_LO:     s_next.rdata[15:0] = s_reg.pu[15:0];
        gcn_pkg::OFF_PULLUP_HI:     s_next.rdata[4:0]  = s_reg.pu[20:16];
        gcn_pkg::OFF_CHG_STATUS:    s_next.rdata[20:0] = s_reg.cn_chg;
        default:                    s_next.rresp = gcn_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_reg.rvalid && RREADY)
    begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      s_reg <= gcn_pkg::STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign AWREADY   = s_reg.awready;
  assign WREADY    = s_reg.wready;
  assign BVALID    = s_reg.bvalid;
  assign BRESP     = s_reg.bresp;
  assign ARREADY   = s_reg.arready;
  assign RVALID    = s_reg.rvalid;
  assign RRESP     = s_reg.rresp;
  assign RDATA     = s_reg.rdata;
  assign PIN_O     = s_reg.pin_o;
  assign PIN_OE_N  = s_reg.pin_oe_n;
  assign PERIPH_IN = s_reg.periph_in;
  assign PULLUP_EN = s_reg.pu;
  assign CN_IRQ    = s_reg.irq;
  assign WAKE_REQ  = s_reg.wake;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_commit(logic [7:0] off);
    s_reg.wst == gcn_pkg::GCN_WR_IDLE && s_reg.aw_got && s_reg.w_got
      && s_reg.aw_addr == off && s_reg.w_strb == 4'hF;
  endsequence

  property p_dir_reset;
    $fell(RST) |-> s_reg.dir == gcn_pkg::IMPL_MASK && PIN_OE_N == 16'hFFFF;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir rst");

  property p_periph_owns;
    1 |=> ((PIN_O ^ $past(PERIPH_OUT)) & $past(own & ~s_reg.odc)
           & gcn_pkg::IMPL_MASK) == 16'h0000;
  endproperty
  a_periph_owns: assert property (p_periph_owns)
    else $error("mux wrong");

  property p_port_drives;
    1 |=> (PIN_OE_N & $past(~own & ~s_reg.dir & ~s_reg.odc)
           & gcn_pkg::IMPL_MASK) == 16'h0000;
  endproperty
  a_port_drives: assert property (p_port_drives)
    else $error("no drive");

  property p_input_dir;
    1 |=> (~PIN_OE_N & $past(~own & s_reg.dir)) == 16'h0000;
  endproperty
  a_input_dir: assert property (p_input_dir) else $error("in drv");

  property p_open_drain;
    1 |=> (PIN_O & $past(s_reg.odc)) == 16'h0000
          && (~PIN_OE_N & $past(s_reg.odc & data_src)) == 16'h0000;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("od hi");

  property p_loop;
    1 |=> (PERIPH_IN & $past(~own & ~s_reg.dir)) == 16'h0000;
  endproperty
  a_loop: assert property (p_loop) else $error("loop through");

  property p_inert;
    (~PIN_OE_N & ~gcn_pkg::IMPL_MASK) == 16'h0000
      && (s_reg.dir & ~gcn_pkg::IMPL_MASK) == 16'h0000;
  endproperty
  a_inert: assert property (p_inert) else $error("inert bit active");

  property p_latch_write;
    s_commit(gcn_pkg::OFF_OUTPUT_LATCH) |=> s_reg.latch
      == ($past(s_reg.w_data[15:0]) & gcn_pkg::IMPL_MASK) && BVALID == 1'b1;
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch");

  property p_level_write;
    s_commit(gcn_pkg::OFF_PIN_LEVEL) |=> s_reg.latch
      == ($past(s_reg.w_data[15:0]) & gcn_pkg::IMPL_MASK);
  endproperty
  a_level_write: assert property (p_level_write) else $error("lvl");

  property p_analog_read;
    ARVALID && ARREADY && ARADDR == gcn_pkg::OFF_PIN_LEVEL
      |=> RVALID && (RDATA[15:0] & $past(s_reg.analog)) == 16'h0000;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("ana");

  property p_cn_set;
    (detect != 21'h000000) |=> CN_IRQ && s_reg.cn_chg == ($past(detect)
      | ($past(s_reg.cn_chg) & ~$past(clr)));
  endproperty
  a_cn_set: assert property (p_cn_set) else $error("lost");

  property p_cn_hold;
    CN_IRQ && clr == 21'h000000 |=> CN_IRQ;
  endproperty
  a_cn_hold: assert property (p_cn_hold) else $error("flag dropped");

  property p_wake;
    SLEEP && detect != 21'h000000 |=> WAKE_REQ;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

endmodule

//--- verif/gcn_pin_model.sv
// pin and board model standing at the far side of the gpio port
`timescale 1ns/10ps

module gcn_pin_model
(
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [15:0] pin_i
);

  // ****************************************************************
  // wire resolution
  // ****************************************************************
  // port or peripheral first, then an outside driver, else board pull-up
  always_comb
  begin
    for (int k = 0; k < 16; k++)
    begin
      if (!pin_oe_n[k])
        pin_i[k] = pin_o[k];
      else if (ext_en[k])
        pin_i[k] = ext_val[k];
      else
        pin_i[k] = 1'b1;
    end
  end

endmodule

//--- verif/tb_top.sv
// self-checking bench for the gpio port block
`timescale 1ns/10ps

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end

module tb_top;

  logic        clock;
  logic        rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] pin_i;
  logic [15:0] pin_o;
  logic [15:0] pin_oe_n;
  logic [15:0] ext_val;
  logic [15:0] ext_en;
  logic [15:0] periph_en;
  logic [15:0] periph_drive;
  logic [15:0] periph_out;
  logic [15:0] periph_in;
  logic [20:0] cn_in;
  logic [20:0] pullup_en;
  logic        sleep;
  logic        cn_irq;
  logic        wake_req;
  int          err_total;
  int          cmp_count;

  // ****************************************************************
  // clock, design and far side
  // ****************************************************************
  initial clock = 1'b0;
  always #50 clock = ~clock;

  gcn_gpio_port i_dut
  (
    .CLOCK(clock), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n),
    .PERIPH_EN(periph_en), .PERIPH_DRIVE(periph_drive),
    .PERIPH_OUT(periph_out), .PERIPH_IN(periph_in),
    .CN_IN(cn_in), .PULLUP_EN(pullup_en), .SLEEP(sleep),
    .CN_IRQ(cn_irq), .WAKE_REQ(wake_req)
  );

  gcn_pin_model i_pins
  (
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
    .ext_en(ext_en), .pin_i(pin_i)
  );

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    resp_of = (a > gcn_pkg::OFF_CHG_STATUS) ? gcn_pkg::RESP_SLVERR
                                            : gcn_pkg::RESP_OKAY;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, resp_of(a))
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] ex);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata & m, ex)
    `CHK(rresp, resp_of(a))
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, sleep, cn_in} = '0;
    {ext_val, ext_en, periph_en, periph_drive, periph_out} = '0;
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    `CHK(pin_oe_n, 16'hFFFF)
    rd(gcn_pkg::OFF_PIN_DIRECTION, 32'hFFFFFFFF, 32'h00009FFF);
    wr(gcn_pkg::OFF_OUTPUT_LATCH, 32'h0000A5A5);
    rd(gcn_pkg::OFF_OUTPUT_LATCH, 32'hFFFFFFFF, 32'h000085A5);
    ext_en  <= 16'hFF00;
    ext_val <= 16'h7234;
    wr(gcn_pkg::OFF_PIN_DIRECTION, 32'h0000FF00);
    cyc(3);
    `CHK(pin_oe_n, 16'hFF00)
    `CHK(pin_o & 16'h00FF, 16'h00A5)
    rd(gcn_pkg::OFF_PIN_DIRECTION, 32'hFFFFFFFF, 32'h00009F00);
    rd(gcn_pkg::OFF_PIN_LEVEL, 32'hFFFFFFFF, 32'h000012A5);
    wr(gcn_pkg::OFF_PIN_LEVEL, 32'h0000005A);
    rd(gcn_pkg::OFF_OUTPUT_LATCH, 32'hFFFFFFFF, 32'h0000005A);
    // analog only on pins that are inputs
    wr(gcn_pkg::OFF_ANALOG_CFG, 32'h00000F00);
    cyc(3);
    rd(gcn_pkg::OFF_PIN_LEVEL, 32'hFFFFFFFF, 32'h0000105A);
    wr(gcn_pkg::OFF_ANALOG_CFG, 32'h00000000);
    wr(gcn_pkg::OFF_OPEN_DRAIN, 32'h0000000F);
    cyc(3);
    `CHK(pin_oe_n[3:0], 4'hA)
    `CHK(pin_o[3:0], 4'h0)
    rd(gcn_pkg::OFF_PIN_LEVEL, 32'h0000000F, 32'h0000000A);
    periph_en    <= 16'h00F0;
    periph_drive <= 16'h0030;
    periph_out   <= 16'h0020;
    cyc(3);
    `CHK(pin_o[7:4], 4'h6)
    `CHK(pin_oe_n[7:4], 4'h0)
    `CHK(periph_in[7:4], 4'h2)
    rd(gcn_pkg::OFF_PIN_LEVEL, 32'h000000F0, 32'h00000060);
    {periph_en, periph_drive, periph_out} <= '0;
    wr(8'h40, 32'h0000FFFF);
    rd(8'h40, 32'hFFFFFFFF, 32'h00000000);
    wr(gcn_pkg::OFF_CHG_EN_LO, 32'h00000001);
    wr(gcn_pkg::OFF_CHG_EN_HI, 32'h00000010);
    rd(gcn_pkg::OFF_CHG_EN_HI, 32'hFFFFFFFF, 32'h00000010);
    cn_in[1] <= 1'b1;
    cyc(3);
    `CHK(cn_irq, 1'b0)
    cn_in[0] <= 1'b1;
    cyc(3);
    `CHK(cn_irq, 1'b1)
    rd(gcn_pkg::OFF_CHG_STATUS, 32'hFFFFFFFF, 32'h00000001);
    wr(gcn_pkg::OFF_CHG_STATUS, 32'h00000001);
    cyc(2);
    `CHK(cn_irq, 1'b0)
    sleep     <= 1'b1;
    cn_in[20] <= 1'b1;
    cyc(3);
    `CHK(wake_req, 1'b1)
    rd(gcn_pkg::OFF_CHG_STATUS, 32'hFFFFFFFF, 32'h00100000);
    sleep <= 1'b0;
    wr(gcn_pkg::OFF_CHG_STATUS, 32'h00100000);
    // pull-ups follow the written bits, on output pins and change-disabled inputs too
    wr(gcn_pkg::OFF_PULLUP_LO, 32'h00008001);
    wr(gcn_pkg::OFF_PULLUP_HI, 32'h0000001F);
    cyc(2);
    `CHK(pullup_en, 21'h1F8001)
    rd(gcn_pkg::OFF_PULLUP_HI, 32'hFFFFFFFF, 32'h0000001F);
    stop_test;
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    stop_test;
  end

endmodule
